//--- rtl/draw_mask_regs.vh
// register map and field constants for the drawing mask / dma base bank
// assumes word-aligned axi4-lite byte addresses, 32-bit data
`ifndef DRAW_MASK_REGS_VH
`define DRAW_MASK_REGS_VH

`define ADDR_DMA_BASE 8'h00
`define ADDR_MASK_WORD 8'h04
`define ADDR_DEPTH_BASE 8'h08
`define ADDR_MODE 8'h0C
`define ADDR_STATUS 8'h10
`define ADDR_SETUP_0 8'h20
`define ADDR_CBUF_PORT 8'h40
`define ADDR_WIDTH 8
`define SETUP_SEL_HI 4
`define SETUP_SEL_LO 2
`define SETUP_BLOCK 3'h1
`define CBUF_BLOCK 3'h2
`define DMA_BASE_RST 32'h00000000
`define MASK_WORD_RST 32'hFFFFFFFF
`define LINE_MASK_BITS 16
`define DWORD_ALIGN_MASK 32'hFFFFFFFC
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
// drawing modes (mode register bits 3:0)
`define MODE_BITS 4
`define MODE_SIMPLE 4'h0
`define MODE_LINE_OPAQUE 4'h1
`define MODE_LINE_TRANSP 4'h2
`define MODE_LINE_INTERP 4'h3
`define MODE_FILL_TRANSP 4'h4
`define MODE_FILL_OPAQUE 4'h5
`define MODE_FILL_BLOCK 4'h6
`define MODE_DMA_READ 4'h7
`define MODE_DMA_WRITE 4'h8
`define CBUF_ENTRIES 8
`define CBUF_IDX_BITS 3

`endif

//--- rtl/draw_mask_dma_base_regs.v
// drawing-control register bank: dma base, mode mask word, line setup
// assumes an axi4-lite master, one clock, engine signals from the core
//
// Overview of operation
// R1: dma base holds a 32-bit physical byte address, low two bits zero
// R2: in dma copy modes a frame write starts transfer at dma base
// R3: software loads only physical pci addresses; no translation here
// R4: dma base and depth base share one storage word
// R5: dma base clears to zero on reset
// R6: line modes use mask bits 15:0; upper bits read zero, ignore writes; the bank stores written upper bits in any mode
// R7: opaque line: set bits foreground, clear bits background
// R8: slope-register line start takes its segment mask from the mask word
// R9: frame write or continue write in line mode takes mask from data
// R10: interpolated lines write set-bit pixels, skip clear-bit pixels
// R11: software loads the mask word before writing a slope register
// R12: fill modes tile the 32-bit mask per aligned 32-pixel span
// R13: transparent fill: set bits foreground, clear bits unchanged
// R14: opaque fill: set bits foreground, clear bits background
// R15: block fill: set bits block colour, clear bits unwritten
// R16: software loads the mask word before the frame write in fills
// R17: dma write copy ands the mask with every outgoing dword
// R18: status write completes only when idle; mask written when idle; the bank accepts mask word writes while the engine is busy
// R19: mask word resets to all ones
// R20: setup write loads dy/dx into stepping engine, no drawing
// R21: software writes line width before any setup register
// R22: setup reads return halves of copy buffer entries 4 to 7
// R23: copy buffer is eight 64-bit entries numbered 0 to 7
`include "draw_mask_regs.vh"

module draw_mask_dma_base_regs
#(
    parameter MODE_RST = 4'h0
)
(
    input wire clk,
    input wire rst_b,
    input wire [7:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output wire s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output wire s_axi_wready,
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    input wire [7:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output wire s_axi_arready,
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    input wire engine_busy,
    input wire fb_write,
    input wire [31:0] fb_wdata,
    input wire continue_write,
    input wire slope_write,
    input wire [31:0] slope_wdata,
    input wire [31:0] dma_wr_data,
    output reg dma_start,
    output reg dma_is_write,
    output reg [31:0] dma_addr,
    output reg [31:0] dma_wr_masked,
    output reg line_go,
    output reg [15:0] line_mask,
    output reg [31:0] line_slope,
    output reg setup_load,
    output reg [15:0] setup_dy,
    output reg [15:0] setup_dx,
    output reg fill_go,
    output reg [31:0] fill_mask,
    output reg [1:0] line_pix_policy,
    output reg [1:0] fill_pix_policy
);

    // pixel policies: what set and clear mask bits do to a pixel
    localparam [1:0] POL_FG_SKIP = 2'h0;
    localparam [1:0] POL_FG_BG = 2'h1;
    localparam [1:0] POL_COL_SKIP = 2'h2;
    localparam [1:0] POL_BLK_SKIP = 2'h3;

    // write channel states, one-hot
    localparam [2:0] WS_IDLE = 3'b001;
    localparam [2:0] WS_HOLD = 3'b010;
    localparam [2:0] WS_RESP = 3'b100;

    reg [31:0] dma_bitmap_base;
    reg [31:0] pixel_mask_word;
    reg [`MODE_BITS-1:0] draw_mode;
    reg [63:0] cbuf [0:`CBUF_ENTRIES-1];
    reg [31:0] cbuf_lo_pend;
    reg [`CBUF_IDX_BITS-1:0] cbuf_wr_idx;
    reg [2:0] wstate;
    reg [2:0] next_wstate;
    reg aw_held;
    reg w_held;
    reg [7:0] aw_addr;
    reg [31:0] w_data;
    reg [3:0] w_strb;
    integer i;

    function is_line;
        input [`MODE_BITS-1:0] m;
        begin
            is_line = (m == `MODE_LINE_OPAQUE) || (m == `MODE_LINE_TRANSP)
                || (m == `MODE_LINE_INTERP);
        end
    endfunction

    function is_fill;
        input [`MODE_BITS-1:0] m;
        begin
            is_fill = (m == `MODE_FILL_TRANSP) || (m == `MODE_FILL_OPAQUE)
                || (m == `MODE_FILL_BLOCK);
        end
    endfunction

    // byte-lane merge used by the dma base and mask word writes
    function [31:0] merge;
        input [31:0] old;
        input [31:0] d;
        input [3:0] s;
        integer b;
        begin
            merge = old;
            for (b = 0; b < 4; b = b + 1)
                if (s[b])
                    merge[b*8 +: 8] = d[b*8 +: 8];
        end
    endfunction

    wire [2:0] aw_block = aw_addr[7:5];
    wire is_status_wr = (aw_addr == `ADDR_STATUS);
    // a status write stalls until the engine is idle, giving an interlock
    wire wr_may_go = aw_held && w_held && !(is_status_wr && engine_busy); // R18
    wire [31:0] merged_base = merge(dma_bitmap_base, w_data, w_strb);

    // addresses and data accepted in any order, then held until done
    assign s_axi_awready = (wstate != WS_RESP) && !aw_held;
    assign s_axi_wready = (wstate != WS_RESP) && !w_held;

    always @*
    begin
        next_wstate = wstate;
        case (wstate)
            WS_IDLE, WS_HOLD:
                if (wr_may_go)
                    next_wstate = WS_RESP;
                else if (aw_held || w_held)
                    next_wstate = WS_HOLD;
            WS_RESP:
                if (s_axi_bready)
                    next_wstate = WS_IDLE;
            default:
                next_wstate = WS_IDLE;
        endcase
    end

    // write side: capture channels, commit registers, answer
    always @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            wstate <= WS_IDLE;
            aw_held <= 1'b0;
            w_held <= 1'b0;
            aw_addr <= 8'h00;
            w_data <= 32'h00000000;
            w_strb <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `RESP_OKAY;
            dma_bitmap_base <= `DMA_BASE_RST; // R5
            pixel_mask_word <= `MASK_WORD_RST; // R19
            draw_mode <= MODE_RST;
            cbuf_lo_pend <= 32'h00000000;
            cbuf_wr_idx <= {`CBUF_IDX_BITS{1'b0}};
            setup_load <= 1'b0;
            setup_dy <= 16'h0000;
            setup_dx <= 16'h0000;
            for (i = 0; i < `CBUF_ENTRIES; i = i + 1)
                cbuf[i] <= 64'h0000000000000000; // R23
        end
        else
        begin
            wstate <= next_wstate;
            setup_load <= 1'b0;
            if (s_axi_awvalid && s_axi_awready)
            begin
                aw_held <= 1'b1;
                aw_addr <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready)
            begin
                w_held <= 1'b1;
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
            end
            if (s_axi_bvalid && s_axi_bready)
                s_axi_bvalid <= 1'b0;
            if (wr_may_go && wstate != WS_RESP)
            begin
                aw_held <= 1'b0;
                w_held <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= `RESP_OKAY;
                if (aw_addr == `ADDR_DMA_BASE || aw_addr == `ADDR_DEPTH_BASE)
                    // one word behind both names; low bits forced aligned
                    dma_bitmap_base <= merged_base & `DWORD_ALIGN_MASK; // R1 R4
                else if (aw_addr == `ADDR_MASK_WORD)
                    pixel_mask_word <= merge(pixel_mask_word, w_data, w_strb);
                else if (aw_addr == `ADDR_MODE)
                    draw_mode <= w_data[`MODE_BITS-1:0];
                else if (is_status_wr)
                    s_axi_bresp <= `RESP_OKAY; // status write is the sync point
                else if (aw_block == `SETUP_BLOCK)
                begin
                    // preset the stepping engine only; nothing is drawn
                    setup_load <= 1'b1; // R20
                    setup_dy <= w_data[31:16]; // R20
                    setup_dx <= w_data[15:0]; // R20
                end
                else if (aw_block == `CBUF_BLOCK && aw_addr[4:2] < 3'h2)
                begin
                    // even port stages low dword, odd port fills the entry
                    if (!aw_addr[2])
                        cbuf_lo_pend <= w_data;
                    else
                    begin
                        cbuf[cbuf_wr_idx] <= {w_data, cbuf_lo_pend};
                        cbuf_wr_idx <= cbuf_wr_idx + 1'b1;
                    end
                end
                else
                    s_axi_bresp <= `RESP_SLVERR;
            end
        end
    end

    // read side: one read outstanding, answer the cycle after address
    assign s_axi_arready = !s_axi_rvalid;
    wire [2:0] ar_block = s_axi_araddr[7:5];
    wire [2:0] ar_sel = s_axi_araddr[`SETUP_SEL_HI:`SETUP_SEL_LO];
    // setup index 0 is entry 7 high; reading has no side effect on the buffer
    wire [`CBUF_IDX_BITS-1:0] rd_entry = 3'h7 - {1'b0, ar_sel[2:1]}; // R22
    wire [63:0] rd_quad = cbuf[rd_entry];

    always @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= `RESP_OKAY;
        end
        else if (s_axi_arvalid && s_axi_arready)
        begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= `RESP_OKAY;
            if (s_axi_araddr == `ADDR_DMA_BASE
                || s_axi_araddr == `ADDR_DEPTH_BASE)
                s_axi_rdata <= dma_bitmap_base; // R4
            else if (s_axi_araddr == `ADDR_MASK_WORD)
                // line modes expose only the 16-bit line mask
                s_axi_rdata <= is_line(draw_mode)
                    ? {16'h0000, pixel_mask_word[15:0]}
                    : pixel_mask_word; // R6
            else if (s_axi_araddr == `ADDR_MODE)
                s_axi_rdata <= {28'h0000000, draw_mode};
            else if (s_axi_araddr == `ADDR_STATUS)
                s_axi_rdata <= {31'h00000000, engine_busy};
            else if (ar_block == `SETUP_BLOCK)
                s_axi_rdata <= ar_sel[0] ? rd_quad[31:0]
                    : rd_quad[63:32]; // R22
            else
            begin
                s_axi_rdata <= 32'h00000000;
                s_axi_rresp <= `RESP_SLVERR;
            end
        end
        else if (s_axi_rready)
            s_axi_rvalid <= 1'b0;
    end

    // engine-facing launches and masks, registered
    always @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            dma_start <= 1'b0;
            dma_is_write <= 1'b0;
            dma_addr <= 32'h00000000;
            dma_wr_masked <= 32'h00000000;
            line_go <= 1'b0;
            line_mask <= 16'h0000;
            line_slope <= 32'h00000000;
            fill_go <= 1'b0;
            fill_mask <= `MASK_WORD_RST;
            line_pix_policy <= POL_FG_SKIP;
            fill_pix_policy <= POL_FG_SKIP;
        end
        else
        begin
            // a frame write in a dma mode launches at the base address
            dma_start <= fb_write && (draw_mode == `MODE_DMA_READ
                || draw_mode == `MODE_DMA_WRITE); // R2
            dma_is_write <= (draw_mode == `MODE_DMA_WRITE);
            dma_addr <= dma_bitmap_base; // R2
            dma_wr_masked <= dma_wr_data & pixel_mask_word; // R17
            line_go <= is_line(draw_mode)
                && (slope_write || fb_write || continue_write);
            if (slope_write)
            begin
                line_slope <= slope_wdata; // R8
                line_mask <= pixel_mask_word[`LINE_MASK_BITS-1:0]; // R8
            end
            else if (continue_write || (fb_write && is_line(draw_mode)))
                line_mask <= fb_wdata[`LINE_MASK_BITS-1:0]; // R9
            fill_go <= fb_write && is_fill(draw_mode);
            fill_mask <= pixel_mask_word; // R12
            case (draw_mode)
                `MODE_LINE_OPAQUE: line_pix_policy <= POL_FG_BG; // R7
                `MODE_LINE_INTERP: line_pix_policy <= POL_COL_SKIP; // R10
                default: line_pix_policy <= POL_FG_SKIP; // R6
            endcase
            case (draw_mode)
                `MODE_FILL_OPAQUE: fill_pix_policy <= POL_FG_BG; // R14
                `MODE_FILL_BLOCK: fill_pix_policy <= POL_BLK_SKIP; // R15
                default: fill_pix_policy <= POL_FG_SKIP; // R13
            endcase
        end
    end

endmodule // draw_mask_dma_base_regs

//--- tb/engine_model.sv
// drawing engine and pci source beside the bank
// assumes kick pulses from the bench; busy span set by BUSY_CYC
module engine_model
#(
    parameter BUSY_CYC = 24
)
(
    input wire clk,
    input wire rst_b,
    input wire kick,
    output logic busy,
    output logic [31:0] dword
);
    timeunit 1ns;
    timeprecision 1ps;
    int left;
    // busy span after each kick; status writes must wait it out
    assign busy = (left != 0);
    // pci dword walks every cycle so a stale value never matches
    always @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            left <= 0;
            dword <= 32'hF0F0F0F0;
        end
        else
        begin
            left <= kick ? BUSY_CYC : (left != 0 ? left - 1 : 0);
            dword <= {dword[30:0], ~dword[31]};
        end
    end
endmodule // engine_model

//--- tb/draw_mask_monitor.sv
// checker on the bank's engine strobes and dma data path
// assumes one clock, rst_b low-active; bound into every bank
module draw_mask_monitor (
    input wire clk,
    input wire rst_b,
    input wire fb_write,
    input wire [31:0] fb_wdata,
    input wire continue_write,
    input wire slope_write,
    input wire [31:0] slope_wdata,
    input wire [31:0] dma_wr_data,
    input wire dma_start,
    input wire dma_is_write,
    input wire [31:0] dma_addr,
    input wire [31:0] dma_wr_masked,
    input wire line_go,
    input wire [15:0] line_mask,
    input wire [31:0] line_slope,
    input wire setup_load,
    input wire fill_go
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_b);
    // launch steps: strobe then line launch next cycle
    sequence slope_launch;
        slope_write ##1 line_go;
    endsequence
    sequence cont_launch;
        continue_write ##1 line_go;
    endsequence
    chk_base_align:
    assert property (dma_addr[1:0] == 2'h0) else $error("base unaligned");
    chk_dma_cause:
    assert property (dma_start |-> $past(fb_write))
        else $error("dma start without frame write");
    chk_line_cause:
    assert property (line_go |-> $past(slope_write) || $past(fb_write)
        || $past(continue_write)) else $error("line launch uncaused");
    chk_slope_data:
    assert property (slope_launch |-> line_slope == $past(slope_wdata))
        else $error("slope data lost");
    chk_cont_mask:
    assert property (cont_launch |-> {16'h0, line_mask} ==
        ($past(fb_wdata) & 32'h0000FFFF)) else $error("continue mask");
    chk_and_mask:
    assert property (dma_is_write && $past(dma_is_write) |->
        (dma_wr_masked & ~$past(dma_wr_data)) == 32'h0)
        else $error("masked dword has extra bits");
    chk_fill_cause:
    assert property (fill_go |-> $past(fb_write) && !line_go && !dma_start)
        else $error("fill launch uncaused");
    chk_setup_quiet:
    assert property (setup_load |-> (!line_go && !fill_go)[*2])
        else $error("setup write drew pixels");
endmodule // draw_mask_monitor

bind draw_mask_dma_base_regs draw_mask_monitor mon (.clk, .rst_b,
    .fb_write, .fb_wdata, .continue_write, .slope_write, .slope_wdata,
    .dma_wr_data, .dma_start, .dma_is_write, .dma_addr, .dma_wr_masked,
    .line_go, .line_mask, .line_slope, .setup_load, .fill_go);

//--- tb/draw_mask_dma_base_regs_tb.sv
// bench for the drawing mask / dma base bank over axi4-lite
// assumes the engine model as far side; bready/rready held high
`include "draw_mask_regs.vh"
module draw_mask_dma_base_regs_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 0, rst_b = 0, kick = 0;
    logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0;
    logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_arvalid = 0;
    logic s_axi_bready = 1, s_axi_rready = 1;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic [31:0] s_axi_wdata = 0, fb_wdata = 0, slope_wdata = 0;
    logic fb_write = 0, continue_write = 0, slope_write = 0;
    logic [31:0] q, setup_seen;
    logic [1:0] r;
    wire engine_busy, s_axi_awready, s_axi_wready, s_axi_bvalid;
    wire s_axi_arready, s_axi_rvalid, dma_start, dma_is_write;
    wire line_go, setup_load, fill_go;
    wire [1:0] s_axi_bresp, s_axi_rresp, line_pix_policy, fill_pix_policy;
    wire [31:0] s_axi_rdata, dma_wr_data, dma_addr, dma_wr_masked;
    wire [31:0] line_slope, fill_mask;
    wire [15:0] line_mask, setup_dy, setup_dx;
    int mismatches = 0, n_checks = 0;
    time t0;

    draw_mask_dma_base_regs dut (.clk, .rst_b, .s_axi_awaddr,
        .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
        .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
        .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
        .engine_busy, .fb_write, .fb_wdata, .continue_write, .slope_write,
        .slope_wdata, .dma_wr_data, .dma_start, .dma_is_write, .dma_addr,
        .dma_wr_masked, .line_go, .line_mask, .line_slope, .setup_load,
        .setup_dy, .setup_dx, .fill_go, .fill_mask, .line_pix_policy,
        .fill_pix_policy);
    engine_model far (.clk, .rst_b, .kick, .busy(engine_busy),
        .dword(dma_wr_data));

    always #20 clk = ~clk;
    // setup pulse falls with the write answer, so latch it
    always @(posedge clk) if (setup_load) setup_seen <= {setup_dy, setup_dx};

    // wide enough for a strobe and a full data word side by side
    task chk(input string nm, input logic [63:0] seen, exp);
        n_checks++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("BAD %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task wrap_up;
        if (mismatches == 0 && n_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    // one write or read; each valid drops at the edge that takes it
    task bus(input logic w, input logic [7:0] a, input logic [31:0] d,
        input logic [3:0] s = 4'hF);
        logic got;
        got = 0;
        s_axi_awaddr <= a;
        s_axi_araddr <= a;
        s_axi_wdata <= d;
        s_axi_wstrb <= s;
        s_axi_awvalid <= w;
        s_axi_wvalid <= w;
        s_axi_arvalid <= !w;
        while (!got)
        begin
            @(posedge clk);
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 0;
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 0;
            got = w ? s_axi_bvalid : s_axi_rvalid;
        end
        r = w ? s_axi_bresp : s_axi_rresp;
        q = s_axi_rdata;
    endtask

    // one-cycle pulse: 0 slope, 1 continue, other frame write
    task strobe(input int which);
        @(posedge clk);
        case (which)
            0: slope_write <= 1;
            1: continue_write <= 1;
            default: fb_write <= 1;
        endcase
        @(posedge clk);
        slope_write <= 0;
        continue_write <= 0;
        fb_write <= 0;
        #1;
    endtask

    task t_reset_and_base;
        bus(0, `ADDR_DMA_BASE, 0);
        chk("base_rst", q, `DMA_BASE_RST);
        bus(0, `ADDR_MASK_WORD, 0);
        chk("mask_rst", q, 32'hFFFFFFFF);
        bus(1, `ADDR_DMA_BASE, 32'h12345677);
        bus(0, `ADDR_DEPTH_BASE, 0);
        chk("base_shared", q, 32'h12345674);
        bus(1, `ADDR_DEPTH_BASE, 32'hA5A5A5A8, 4'h3);
        bus(0, `ADDR_DMA_BASE, 0);
        chk("depth_shared", q, 32'h1234A5A8);
        bus(0, 8'h80, 0);
        chk("unmapped", {r, q}, {`RESP_SLVERR, 32'h0});
    endtask

    // mask word loaded before any slope write
    task t_line;
        bus(1, `ADDR_MASK_WORD, 32'hABCD1234);
        for (int m = 1; m <= 3; m++)
        begin
            bus(1, `ADDR_MODE, m);
            bus(0, `ADDR_MASK_WORD, 0);
            chk("mask_line_rd", q, 32'h00001234);
            slope_wdata <= 32'h00030007 + m;
            strobe(0);
            chk("slope_mask", {line_go, line_mask}, 17'h11234);
            chk("slope_data", line_slope, 32'h00030007 + m);
            chk("policy", line_pix_policy, m == 1 ? 1 : 2 * (m - 2));
            fb_wdata <= 32'hFFFF5A50 + m;
            strobe(1);
            chk("cont_mask", line_mask, 16'h5A50 + m);
            strobe(2);
            chk("fb_mask", {line_go, line_mask}, 17'h15A50 + m);
        end
    endtask

    // mask stays loaded from the line pass before each fill launch
    task t_fill;
        for (int m = 4; m <= 6; m++)
        begin
            bus(1, `ADDR_MODE, m);
            bus(0, `ADDR_MASK_WORD, 0);
            chk("mask_fill_rd", q, 32'hABCD1234);
            strobe(2);
            chk("fill_mask", {fill_go, fill_mask}, 33'h1ABCD1234);
            chk("fill_policy", fill_pix_policy, m == 6 ? 3 : m - 4);
        end
    endtask

    task t_dma;
        bus(1, `ADDR_DMA_BASE, 32'h00C0FFE0);
        bus(1, `ADDR_MODE, `MODE_DMA_READ);
        strobe(2);
        chk("dma_rd", {dma_start, dma_is_write, dma_addr}, 34'h200C0FFE0);
        bus(1, `ADDR_MODE, `MODE_DMA_WRITE);
        bus(1, `ADDR_MASK_WORD, 32'h0F0F00FF);
        strobe(2);
        chk("dma_wr", {dma_start, dma_is_write}, 2'h3);
        @(posedge clk);
        q = dma_wr_data;
        #1;
        chk("dma_and", dma_wr_masked, q & 32'h0F0F00FF);
        kick <= 1;
        @(posedge clk);
        kick <= 0;
        t0 = $time;
        bus(1, `ADDR_STATUS, 0);
        chk("status_wait", {engine_busy, ($time - t0) >= 800}, 2'h1);
    endtask

    task t_setup;
        bus(1, `ADDR_SETUP_0 + 8'h0C, 32'h00070009);
        // the latch updates at the edge that ends the write
        #1;
        chk("setup_fields", setup_seen, 32'h00070009);
        for (int e = 0; e < 8; e++)
        begin
            bus(1, `ADDR_CBUF_PORT, 32'h100 + e);
            bus(1, `ADDR_CBUF_PORT + 8'h04, 32'h200 + e);
        end
        for (int n = 0; n < 9; n++)
        begin
            bus(0, `ADDR_SETUP_0 + 4 * (n % 8), 0);
            chk("setup_rd", q, (n % 2 ? 32'h100 : 32'h200) + 7 - (n % 8) / 2);
        end
    endtask

    initial
    begin
        repeat (10) @(posedge clk);
        rst_b <= 1;
        t_reset_and_base;
        t_line;
        t_fill;
        t_dma;
        t_setup;
        wrap_up;
    end

    // cuts a hang short well past the few hundred cycles needed
    initial
    begin
        repeat (20000) @(posedge clk);
        mismatches++;
        wrap_up;
    end
endmodule // draw_mask_dma_base_regs_tb
